/* nvm_cfg_params.svh */
// Constants for the boost, pump and thermal configuration register bank
`ifndef NVM_CFG_PARAMS_SVH
`define NVM_CFG_PARAMS_SVH

// -----------------------------------------------------------------------------
// Register offsets on the host serial port
// -----------------------------------------------------------------------------
`define OFS_BOOST_TIMING_SLEW 8'h75
`define OFS_SUPPLY_PUMP 8'h76
`define OFS_EXT_THERMAL_LIMITS 8'h77
`define OFS_THERMAL_DERATING 8'h78

// -----------------------------------------------------------------------------
// Reset values and writable-bit masks
// -----------------------------------------------------------------------------
`define RST_BOOST_TIMING_SLEW 8'h06
`define RST_SUPPLY_PUMP 8'h8c
`define RST_EXT_THERMAL_LIMITS 8'hff
`define RST_THERMAL_DERATING 8'h3e
`define MASK_BOOST_TIMING_SLEW 8'hf7
`define MASK_SUPPLY_PUMP 8'h8f
`define MASK_EXT_THERMAL_LIMITS 8'hff
`define MASK_THERMAL_DERATING 8'hff

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define F_OFF_TIME 7:6
`define F_BLANK_TIME 5:4
`define F_SLEW 2:0
`define F_LOCKOUT 7
`define F_PUMP_CLK 3:2
`define F_PUMP_EN 1
`define F_SQUARE_EN 0
`define F_NTC_UPPER 7:4
`define F_NTC_LOWER 3:0
`define F_DERATE 7:6
`define F_STEP_PERIOD 5:1
`define F_NTC_EN 0

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define CLK_MHZ 125
`define SQW_HALF_NS 5000
`define SQW_HALF_CYCLES ((`SQW_HALF_NS * `CLK_MHZ) / 1000)
`define SECOND_CYCLES 125000000

`endif

/* nvm_cfg_pkg.sv */
// Types for the boost, pump and thermal configuration register bank
package nvm_cfg_pkg;

  // ---------------------------------------------------------------------------
  // Complete state of the register bank
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0][7:0] regs;
    logic [7:0] rd_data;
    logic [4:0] slew_cnt;
    logic slew_step;
    logic [31:0] tick_cnt;
    logic [6:0] sec_cnt;
    logic ntc_step;
    logic [9:0] sqw_cnt;
    logic pump_square_out_pin;
    logic sqw_run;
    logic pump_on;
    logic [7:0] off_time_ns;
    logic [7:0] blank_time_ns;
    logic [4:0] slew_div;
    logic lockout_3v0;
    logic [9:0] pump_clk_khz;
    logic [13:0] upper_res;
    logic [13:0] lower_res;
    logic [6:0] derate_c;
    logic derate_en;
    logic [6:0] step_s;
    logic ntc_en;
  } cfg_state_s;

endpackage

/* boost_cp_thermal_nvm_config.sv */
// Boost, charge pump and thermal configuration register bank
`timescale 1ns/1ps
`include "nvm_cfg_params.svh"

module boost_cp_thermal_nvm_config #(
  parameter int SECOND_CYCLES = `SECOND_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host serial port register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Sequencing events from the rest of the device
  input wire logic soft_start,
  input wire logic pwm_cycle_start,
  // Boost converter settings
  output logic [7:0] off_time_ns,
  output logic [7:0] blank_time_ns,
  output logic [4:0] slew_div,
  output logic slew_step,
  // Supply and charge pump
  output logic lockout_3v0,
  output logic [9:0] pump_clk_khz,
  output logic pump_on,
  output logic pump_square_out_pin,
  // Thermal derating
  output logic [13:0] ntc_upper_res,
  output logic [13:0] ntc_lower_res,
  output logic derate_en,
  output logic [6:0] derate_c,
  output logic [6:0] ntc_step_s,
  output logic ntc_comp_enable,
  output logic ntc_step
);

  // ---------------------------------------------------------------------------
  // Lookup tables
  // ---------------------------------------------------------------------------

  // Both tables are pure decodes of stored bits and hold no state.

  // Resistance in units of 10 ohm, shared by both THERMISTOR_SENSOR limits.
  // Hundredths of a kilohm keep every entry exact in 14 bits, so the
  // comparator downstream sees the same figures software programmed.
  // The table falls with the code: a higher code means a hotter limit.
  function automatic logic [13:0] ntc_res(input logic [3:0] code);
    logic [13:0] r;
    r = 14'h0000;
    unique case (code)
      4'h0: r = 14'd7967;
      4'h1: r = 14'd4335;
      4'h2: r = 14'd2977;
      4'h3: r = 14'd2267;
      4'h4: r = 14'd1830;
      4'h5: r = 14'd1534;
      4'h6: r = 14'd1321;
      4'h7: r = 14'd1160;
      4'h8: r = 14'd1034;
      4'h9: r = 14'd932;
      4'ha: r = 14'd849;
      4'hb: r = 14'd779;
      4'hc: r = 14'd720;
      4'hd: r = 14'd669;
      4'he: r = 14'd625;
      4'hf: r = 14'd587;
    endcase
    return r;
  endfunction

  // PWM cycles between slew steps.
  // Codes 0 to 5 count up by one; the two top codes jump to 8 and 16,
  // which is why this is a table and not a plain add.
  function automatic logic [4:0] slew_cycles(input logic [2:0] code);
    logic [4:0] n;
    n = 5'h01;
    unique case (code)
      3'h6: n = 5'h08;
      3'h7: n = 5'h10;
      default: n = {2'h0, code} + 5'h01;
    endcase
    return n;
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  // Registered copy and its next value; every output is read from st,
  // so no port carries a combinational path from the host bus.
  nvm_cfg_pkg::cfg_state_s st;
  nvm_cfg_pkg::cfg_state_s next_st;

  // Masks and reset images come from the header, so a changed reset
  // value or a newly reserved bit needs no edit in this file.
  localparam logic [7:0] base_ofs = `OFS_BOOST_TIMING_SLEW;
  localparam logic [31:0] tick_last = 32'(SECOND_CYCLES - 1);
  localparam logic [9:0] sqw_last = 10'(`SQW_HALF_CYCLES - 1);
  localparam logic [3:0][7:0] reg_mask = {`MASK_THERMAL_DERATING,
    `MASK_EXT_THERMAL_LIMITS, `MASK_SUPPLY_PUMP, `MASK_BOOST_TIMING_SLEW};
  localparam logic [3:0][7:0] reg_reset = {`RST_THERMAL_DERATING,
    `RST_EXT_THERMAL_LIMITS, `RST_SUPPLY_PUMP, `RST_BOOST_TIMING_SLEW};

  // The four registers sit back to back above the base offset, so one
  // subtraction and one compare give both the hit and the index.
  logic [7:0] rel_addr;
  logic hit;
  logic [7:0] r21;
  logic [7:0] r22;
  logic [7:0] r23;
  logic [7:0] r24;
  logic [6:0] step_len;

  assign rel_addr = reg_addr - base_ofs;
  assign hit = (rel_addr < 8'h04);
  // Short aliases for the four stored registers
  assign r21 = st.regs[0];
  assign r22 = st.regs[1];
  assign r23 = st.regs[2];
  assign r24 = st.regs[3];
  // Step length in seconds: twice the code plus two, at most 64
  assign step_len = {1'b0, r24[`F_STEP_PERIOD], 1'b0} + 7'h02;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    // Start from the held state; the two strobes are one-cycle pulses
    // and drop back to zero unless their counter fires this cycle.
    next_st = st;
    next_st.slew_step = 1'b0;
    next_st.ntc_step = 1'b0;

    // Register writes; masked bits stay zero whatever the host sends.
    // An address outside the bank never matches, so stray writes to
    // neighbouring registers leave this bank untouched.
    for (int i = 0; i < 4; i++) begin
      if (reg_wr && hit && rel_addr[1:0] == 2'(i)) begin
        next_st.regs[i] = reg_wdata & reg_mask[i];
      end
    end

    // Unmapped reads give zero; the read data holds until the next read.
    // A write and a read in the same cycle return the old contents,
    // because the read takes the stored value before the write lands.
    if (reg_rd) begin
      next_st.rd_data = hit ? st.regs[rel_addr[1:0]] : 8'h00;
    end

    // Decoded boost timing.
    // Figures are in nanoseconds, so the switch controller needs no
    // table of its own; they are re-decoded every cycle from the register.
    unique case (r21[`F_OFF_TIME])
      2'h0: next_st.off_time_ns = 8'd131;
      2'h1: next_st.off_time_ns = 8'd68;
      2'h2: next_st.off_time_ns = 8'd38;
      2'h3: next_st.off_time_ns = 8'd24;
    endcase
    unique case (r21[`F_BLANK_TIME])
      2'h0: next_st.blank_time_ns = 8'd162;
      2'h1: next_st.blank_time_ns = 8'd88;
      2'h2: next_st.blank_time_ns = 8'd63;
      2'h3: next_st.blank_time_ns = 8'd40;
    endcase
    next_st.slew_div = slew_cycles(r21[`F_SLEW]);

    // Slew pacing: one step pulse every slew_div PWM cycles.
    // The count is not cleared when the pace changes; a shorter pace
    // may fire one early step, but never misses one.
    if (pwm_cycle_start) begin
      if (st.slew_cnt + 5'h01 >= st.slew_div) begin
        next_st.slew_cnt = 5'h00;
        next_st.slew_step = 1'b1;
      end else begin
        next_st.slew_cnt = st.slew_cnt + 5'h01;
      end
    end

    // Supply lockout and pump clock selection.
    // The lower lockout level is only safe with a slow PLL; that choice
    // belongs to the configuring software, this bank just passes it on.
    next_st.lockout_3v0 = r22[`F_LOCKOUT];
    unique case (r22[`F_PUMP_CLK])
      2'h0: next_st.pump_clk_khz = 10'd104;
      2'h1: next_st.pump_clk_khz = 10'd208;
      2'h2: next_st.pump_clk_khz = 10'd417;
      2'h3: next_st.pump_clk_khz = 10'd833;
    endcase

    // Pump and square wave start only at soft start, stop when bit clears.
    // Setting an enable bit alone does nothing until the next soft start,
    // while clearing it stops pump_on within one cycle and the square pin within two.
    if (!r22[`F_PUMP_EN]) begin
      next_st.pump_on = 1'b0;
    end else if (soft_start) begin
      next_st.pump_on = 1'b1;
    end
    if (!r22[`F_SQUARE_EN]) begin
      next_st.sqw_run = 1'b0;
    end else if (soft_start) begin
      next_st.sqw_run = 1'b1;
    end

    // Equal high and low halves give the 50% duty cycle.
    // Each half is 625 clock cycles, 5 us at the 125 MHz system clock;
    // the pin is forced low when stopped so it never parks high.
    if (st.sqw_run) begin
      if (st.sqw_cnt == sqw_last) begin
        next_st.sqw_cnt = 10'h000;
        next_st.pump_square_out_pin = ~st.pump_square_out_pin;
      end else begin
        next_st.sqw_cnt = st.sqw_cnt + 10'h001;
      end
    end else begin
      next_st.sqw_cnt = 10'h000;
      next_st.pump_square_out_pin = 1'b0;
    end

    // Thermal thresholds.
    // Derating code 0 switches the function off and reports 0 degrees,
    // so the enable and the temperature never disagree.
    next_st.upper_res = ntc_res(r23[`F_NTC_UPPER]);
    next_st.lower_res = ntc_res(r23[`F_NTC_LOWER]);
    next_st.derate_en = (r24[`F_DERATE] != 2'h0);
    unique case (r24[`F_DERATE])
      2'h0: next_st.derate_c = 7'd0;
      2'h1: next_st.derate_c = 7'd90;
      2'h2: next_st.derate_c = 7'd100;
      2'h3: next_st.derate_c = 7'd110;
    endcase
    next_st.step_s = step_len;
    next_st.ntc_en = r24[`F_NTC_EN];

    // Step timer runs only while compensation is on, so it restarts cleanly.
    // The seconds prescaler is a parameter so simulation can shorten it;
    // a full-length second is 125 million cycles of the system clock.
    if (!r24[`F_NTC_EN]) begin
      next_st.tick_cnt = 32'h0000_0000;
      next_st.sec_cnt = 7'h00;
    end else if (st.tick_cnt >= tick_last) begin
      next_st.tick_cnt = 32'h0000_0000;
      if (st.sec_cnt + 7'h01 >= step_len) begin
        next_st.sec_cnt = 7'h00;
        next_st.ntc_step = 1'b1;
      end else begin
        next_st.sec_cnt = st.sec_cnt + 7'h01;
      end
    end else begin
      next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Synchronous reset loads the stored-bank image and clears the pulses;
  // the decoded outputs follow from it one edge after reset is released,
  // which is why they read zero while reset is held, except slew_div, which reads one.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= '0;
      st.regs <= reg_reset;
      st.slew_div <= 5'h01;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops.
  // Plain wires only, so every port changes just after a clock edge.
  assign reg_rdata = st.rd_data;
  assign off_time_ns = st.off_time_ns;
  assign blank_time_ns = st.blank_time_ns;
  assign slew_div = st.slew_div;
  assign slew_step = st.slew_step;
  assign lockout_3v0 = st.lockout_3v0;
  assign pump_clk_khz = st.pump_clk_khz;
  assign pump_on = st.pump_on;
  assign pump_square_out_pin = st.pump_square_out_pin;
  assign ntc_upper_res = st.upper_res;
  assign ntc_lower_res = st.lower_res;
  assign derate_en = st.derate_en;
  assign derate_c = st.derate_c;
  assign ntc_step_s = st.step_s;
  assign ntc_comp_enable = st.ntc_en;
  assign ntc_step = st.ntc_step;

endmodule

/* cfg_bank_checker.sv */
// Concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
module cfg_bank_checker #(
  parameter int SECOND_CYCLES = 10
) (
  // Clock, reset and register port
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Events and decoded settings
  input wire logic soft_start,
  input wire logic pwm_cycle_start,
  input wire logic [7:0] off_time_ns,
  input wire logic [7:0] blank_time_ns,
  input wire logic slew_step,
  input wire logic lockout_3v0,
  input wire logic [9:0] pump_clk_khz,
  input wire logic pump_on,
  input wire logic pump_square_out_pin,
  input wire logic [13:0] ntc_upper_res,
  input wire logic [13:0] ntc_lower_res,
  input wire logic ntc_comp_enable
);
  // ---------------------------------------------------------------
  // Write decodes; a setting follows its write two edges later
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire w75 = reg_wr && reg_addr == 8'h75;
  wire w76 = reg_wr && reg_addr == 8'h76;
  wire w77 = reg_wr && reg_addr == 8'h77;
  wire w78 = reg_wr && reg_addr == 8'h78;
  // Read of the first register, then the strobe released
  sequence s_rd75; reg_rd && reg_addr == 8'h75 ##1 !reg_rd; endsequence
  property p_off; w75 && reg_wdata[7:6] == 2'h3 |-> ##2 off_time_ns == 8'h18; endproperty
  a_off: assert property (p_off) else $error("off time decode wrong");
  property p_blank; w75 && reg_wdata[5:4] == 2'h0 |-> ##2 blank_time_ns == 8'ha2; endproperty
  a_blank: assert property (p_blank) else $error("blank time decode wrong");
  property p_slew; slew_step |-> $past(pwm_cycle_start); endproperty
  a_slew: assert property (p_slew) else $error("slew step without pwm cycle");
  property p_lock; w76 |-> ##2 lockout_3v0 == $past(reg_wdata[7], 2); endproperty
  a_lock: assert property (p_lock) else $error("lockout level wrong");
  property p_pclk; w76 && reg_wdata[3:2] == 2'h3 |-> ##2 pump_clk_khz == 10'h341; endproperty
  a_pclk: assert property (p_pclk) else $error("pump clock decode wrong");
  property p_pon; $rose(pump_on) |-> $past(soft_start); endproperty
  a_pon: assert property (p_pon) else $error("pump started without soft start");
  // High phase of the square pin is counted here, never over 625 cycles
  logic [9:0] sq_hi;
  always_ff @(posedge clk_sys) begin
    if (rst || !pump_square_out_pin) begin
      sq_hi <= 10'h000;
    end else begin
      sq_hi <= sq_hi + 10'h001;
    end
  end
  property p_sq; pump_square_out_pin |-> sq_hi < 10'h271; endproperty
  a_sq: assert property (p_sq) else $error("square wave high time wrong");
  property p_up; w77 && reg_wdata[7:4] == 4'h0 |-> ##2 ntc_upper_res == 14'h1f1f; endproperty
  a_up: assert property (p_up) else $error("upper limit decode wrong");
  property p_lo; w77 && reg_wdata[3:0] == 4'hf |-> ##2 ntc_lower_res == 14'h24b; endproperty
  a_lo: assert property (p_lo) else $error("lower limit decode wrong");
  property p_comp; w78 |-> ##2 ntc_comp_enable == $past(reg_wdata[0], 2); endproperty
  a_comp: assert property (p_comp) else $error("compensation enable wrong");
  property p_rsv; s_rd75 |=> !reg_rdata[3]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
endmodule
bind boost_cp_thermal_nvm_config cfg_bank_checker #(.SECOND_CYCLES(SECOND_CYCLES)) chk_u (.*);

/* tb.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`include "nvm_cfg_params.svh"
module tb;
  // ---------------------------------------------------------------
  // Stimulus, observed outputs and expectation tables
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic soft_start = 1'b0, pwm_cycle_start = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, off_time_ns, blank_time_ns;
  logic [4:0] slew_div;
  logic [9:0] pump_clk_khz;
  logic [13:0] ntc_upper_res, ntc_lower_res;
  logic [6:0] derate_c, ntc_step_s;
  logic slew_step, lockout_3v0, pump_on, pump_square_out_pin, derate_en, ntc_comp_enable, ntc_step;
  int err_count = 0, checks = 0, n;
  logic [7:0] offt [4] = '{8'h83, 8'h44, 8'h26, 8'h18};
  logic [7:0] blnk [4] = '{8'ha2, 8'h58, 8'h3f, 8'h28};
  logic [9:0] khz [4] = '{10'h068, 10'h0d0, 10'h1a1, 10'h341};
  logic [6:0] degc [4] = '{7'h00, 7'h5a, 7'h64, 7'h6e};
  logic [13:0] res [16] = '{14'h1f1f, 14'h10ef, 14'hba1, 14'h8db, 14'h726, 14'h5fe, 14'h529,
    14'h488, 14'h40a, 14'h3a4, 14'h351, 14'h30b, 14'h2d0, 14'h29d, 14'h271, 14'h24b};
  // Rows: address, write data, expected read-back
  logic [23:0] rows [26] = '{24'h75fff7, 24'h750000, 24'h755951, 24'h75a2a2, 24'h75f3f3,
    24'h750404, 24'h755555, 24'h75a6a6, 24'h76ff8f, 24'h760000, 24'h767404, 24'h760808,
    24'h770101, 24'h772323, 24'h774545, 24'h776767, 24'h778989, 24'h77abab, 24'h77cdcd,
    24'h77efef, 24'h780000, 24'h787f7f, 24'h78bcbc, 24'h78c2c2, 24'h74ff00, 24'h79ff00};
  logic [7:0] rv [4] = '{`RST_BOOST_TIMING_SLEW, `RST_SUPPLY_PUMP, `RST_EXT_THERMAL_LIMITS,
    `RST_THERMAL_DERATING};

  boost_cp_thermal_nvm_config #(.SECOND_CYCLES(10)) dut_u (.*);

  // Free-running 125 MHz clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Tasks and decode models
  // ---------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Strobes last one cycle; the next edge passes before any new request
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
  endtask
  function automatic logic [31:0] obs(input logic [7:0] a);
    case (a)
      8'h75: obs = {off_time_ns, blank_time_ns, 11'h0, slew_div};
      8'h76: obs = {21'h0, lockout_3v0, pump_clk_khz};
      8'h77: obs = {4'h0, ntc_upper_res, ntc_lower_res};
      default: obs = {16'h0, derate_en, derate_c, ntc_step_s, ntc_comp_enable};
    endcase
  endfunction
  function automatic logic [31:0] want(input logic [7:0] a, input logic [7:0] d);
    logic [4:0] s;
    s = (d[2:0] < 3'h6) ? {2'h0, d[2:0]} + 5'h1 : (d[0] ? 5'h10 : 5'h08);
    case (a)
      8'h75: want = {offt[d[7:6]], blnk[d[5:4]], 11'h0, s};
      8'h76: want = {21'h0, d[7], khz[d[3:2]]};
      8'h77: want = {4'h0, res[d[7:4]], res[d[3:0]]};
      default: want = {16'h0, d[7:6] != 2'h0, degc[d[7:6]], {1'b0, d[5:1], 1'b0} + 7'h2, d[0]};
    endcase
  endfunction
  // Period between two rising edges of the square pin or the step pulse
  task gap(input bit sel, input int exp_n);
    int r;
    logic p, v;
    n = 0;
    r = 0;
    p = 1'b1;
    while (r < 2) begin
      @(negedge clk_sys);
      v = sel ? ntc_step : pump_square_out_pin;
      if (v && !p) r++;
      if (r == 1) n++;
      p = v;
    end
    chk(n, exp_n);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk(reg_rdata, rows[i][7:0]);
      if (rows[i][23:16] inside {[8'h75:8'h78]}) begin
        chk(obs(rows[i][23:16]), want(rows[i][23:16], rows[i][15:8]));
      end
      chk(pump_on, 1'b0);
    end
    $display("table rows done");
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(8'h75 + 8'(a));
      chk(reg_rdata, rv[a]);
      chk(obs(8'h75 + 8'(a)), want(8'h75 + 8'(a), rv[a]));
    end
    $display("reset values done");
    // Slew every third PWM cycle: nine cycles give three steps
    wr(8'h75, 8'h02);
    n = 0;
    repeat (9) begin
      pwm_cycle_start = 1'b1;
      repeat (4) begin
        @(negedge clk_sys);
        pwm_cycle_start = 1'b0;
        n += int'(slew_step);
      end
    end
    chk(n, 3);
    $display("slew pace done");
    // Lower lockout level picked: the bench's PLL is taken to run slowly
    wr(8'h76, 8'h03);
    soft_start = 1'b1;
    @(negedge clk_sys);
    soft_start = 1'b0;
    @(negedge clk_sys);
    chk(pump_on, 1'b1);
    gap(1'b0, 2 * `SQW_HALF_CYCLES);
    wr(8'h76, 8'h00);
    soft_start = 1'b1;
    @(negedge clk_sys);
    soft_start = 1'b0;
    @(negedge clk_sys);
    chk({pump_on, pump_square_out_pin}, 2'h0);
    $display("soft start done");
    // Step code 1 is four seconds of ten cycles each
    wr(8'h78, 8'h03);
    gap(1'b1, 40);
    $display("thermal step done");
    print_verdict();
  end
endmodule
